// ### core/rcw_watchdog.sv
// reconfiguration watchdog: session sequencing, trigger capture and counter control
`timescale 1ns/1ps
`default_nettype none
module rcw_watchdog (
  input  wire logic                           core_clk,
  input  wire logic                           nrst,
  input  wire logic                           watchdogReloadN,
  input  wire logic                           configRestartN,
  input  wire logic                           configErrorN,
  input  wire logic                           crcError,
  input  wire logic                           coreReconfigReq,
  input  wire logic                           userModeEntry,
  input  wire logic                           factoryWrite,
  input  wire logic [rcw_pkg::CTRL_WIDTH-1:0] factoryData,
  input  wire logic [rcw_pkg::CTRL_WIDTH-1:0] updateData,
  input  wire logic                           userClockSelect,
  input  wire logic                           oscTick,
  input  wire logic                           userClockInputTick,
  output logic      [rcw_pkg::CTRL_WIDTH-1:0] controlReg,
  output logic      [rcw_pkg::STAT_WIDTH-1:0] statusReg,
  output logic                                watchdogTimeout,
  output logic                                factoryLoad,
  output logic                                userMode
);

  ////////////////////////////////////////////////////////////////////////////////
  // state and decode

  rcw_pkg::rcw_state_t state_q;
  rcw_pkg::rcw_state_t state_d;
  logic                timeout_q;
  logic                factoryLoad_q;
  logic                userMode_q;
  logic                timedOut_q;

  rcw_cnt_if cntBus ();

  wire logic inLoad   = (state_q == rcw_pkg::ST_LOAD);
  wire logic inUser   = (state_q == rcw_pkg::ST_USER);
  wire logic inStatus = (state_q == rcw_pkg::ST_STATUS);
  wire logic inReconf = (state_q == rcw_pkg::ST_RECONF);

  wire logic wdEnabled = controlReg[rcw_pkg::CTRL_EN_BIT];
  wire logic reloadReq = !watchdogReloadN;
  // ticks stand for the slow counter clocks, sampled in the core domain
  wire logic counterTick = userClockSelect ? userClockInputTick : oscTick;

  wire logic restartEv = !configRestartN;
  wire logic errorEv   = !configErrorN;
  wire logic crcEv     = crcError && inLoad;
  wire logic coreEv    = coreReconfigReq && inUser;
  // one-shot: a second expiry in the same session is ignored
  wire logic wdEv      = cntBus.expired && inUser && wdEnabled && !timedOut_q;

  wire logic [rcw_pkg::STAT_WIDTH-1:0] causeVec = {wdEv, coreEv, crcEv, errorEv, restartEv};
  // triggers are not taken while the factory load request is out
  wire logic trigger   = (causeVec != '0) && !inStatus && !inReconf;
  wire logic enterUser = inLoad && userModeEntry && !trigger;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencing

  always_comb begin
    state_d = state_q;
    case (state_q)
      rcw_pkg::ST_LOAD: begin
        if (trigger) begin
          state_d = rcw_pkg::ST_STATUS;
        end else if (userModeEntry) begin
          state_d = rcw_pkg::ST_USER;
        end
      end
      rcw_pkg::ST_USER: begin
        if (trigger) begin
          state_d = rcw_pkg::ST_STATUS;
        end
      end
      // status is written on the trigger edge, so the load waits one cycle
      rcw_pkg::ST_STATUS: state_d = rcw_pkg::ST_RECONF;
      rcw_pkg::ST_RECONF: state_d = rcw_pkg::ST_LOAD;
      default:            state_d = rcw_pkg::ST_LOAD;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_q <= rcw_pkg::ST_LOAD;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      timeout_q     <= 1'b0;
      factoryLoad_q <= 1'b0;
      userMode_q    <= 1'b0;
      timedOut_q    <= 1'b0;
    end else begin
      timeout_q     <= wdEv && !inStatus && !inReconf;
      factoryLoad_q <= inStatus;
      userMode_q    <= (state_d == rcw_pkg::ST_USER);
      timedOut_q    <= enterUser ? 1'b0 : (timedOut_q || wdEv);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // counter control

  assign cntBus.reloadValue = {controlReg[rcw_pkg::FIELD_WIDTH-1:0], rcw_pkg::LOW_CONST};
  assign cntBus.load = enterUser || (inUser && reloadReq);
  // held reload keeps the count parked at its reload value
  assign cntBus.step = inUser && wdEnabled && counterTick && !reloadReq && !timedOut_q;

  rcw_down_counter #(
    .WIDTH (rcw_pkg::CNT_WIDTH)
  ) uCounter (
    .core_clk (core_clk),
    .nrst     (nrst),
    .cnt      (cntBus.cnt)
  );

  rcw_ctrl_regs uRegs (
    .core_clk     (core_clk),
    .nrst         (nrst),
    .factoryWrite (factoryWrite && inLoad),
    .factoryData  (factoryData),
    .updateData   (updateData),
    .statusLoad   (trigger),
    .causeVec     (causeVec),
    .controlReg   (controlReg),
    .statusReg    (statusReg)
  );

  assign watchdogTimeout = timeout_q;
  assign factoryLoad     = factoryLoad_q;
  assign userMode        = userMode_q;

endmodule : rcw_watchdog
`default_nettype wire

// ### core/rcw_pkg.sv
// constants, states and the operation summary for the reconfiguration watchdog
// Operation
// - the status register is written by the error logic one cycle before the factory load request is raised.
// - restart, error, crc and time-out triggers clear the control register to zero, a core trigger alone loads it from the update register.
// - the watchdog counts down from the value that the factory configuration wrote into the control register.
// - the watchdog counter is 29 bits wide.
// - the reload value is the 12-bit timeout field with the fixed 17-bit constant appended below it.
// - each step of the timeout field changes the period by two to the power 17 counter ticks.
// - the counter advances on ticks of either the 10 MHz internal oscillator or the user clock of up to 40 MHz.
// - counting starts only after the application configuration has entered user mode.
// - an expired count raises an internal time-out signal toward the upgrade control logic.
// - a time-out sets the watchdog time-out flag in the status register and then requests the factory load.
// - crc errors seen while the configuration loads are a reconfiguration error source.
package rcw_pkg;

  localparam int unsigned CNT_WIDTH   = 29;
  localparam int unsigned FIELD_WIDTH = 12;
  localparam int unsigned LOW_WIDTH   = 17;
  localparam logic [LOW_WIDTH-1:0] LOW_CONST = 17'h00008;

  localparam int unsigned CTRL_WIDTH    = 13;
  localparam int unsigned CTRL_EN_BIT   = 12;
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 13'h0000;

  localparam int unsigned STAT_WIDTH   = 5;
  localparam int unsigned STAT_RESTART = 0;
  localparam int unsigned STAT_ERROR   = 1;
  localparam int unsigned STAT_CRC     = 2;
  localparam int unsigned STAT_CORE    = 3;
  localparam int unsigned STAT_WD      = 4;
  localparam logic [STAT_WIDTH-1:0] STAT_RESET = 5'h00;

  localparam int unsigned OSC_FREQ_MHZ     = 10;
  localparam int unsigned USER_CLK_MAX_MHZ = 40;
  localparam int unsigned RELOAD_MIN_NS    = 250;
  localparam int unsigned CORE_CLK_MHZ     = 200;
  localparam int unsigned RELOAD_MIN_CYC   = (RELOAD_MIN_NS * CORE_CLK_MHZ + 999) / 1000;

  typedef enum logic [3:0] {
    ST_LOAD    = 4'h1,
    ST_USER    = 4'h2,
    ST_STATUS  = 4'h4,
    ST_RECONF  = 4'h8
  } rcw_state_t;

endpackage : rcw_pkg

// ### core/rcw_cnt_if.sv
// interface between the watchdog control and its down-counter
`timescale 1ns/1ps
`default_nettype none
interface rcw_cnt_if;
  logic                         load;
  logic                         step;
  logic [rcw_pkg::CNT_WIDTH-1:0] reloadValue;
  logic [rcw_pkg::CNT_WIDTH-1:0] count;
  logic                         expired;

  modport ctrl (output load, output step, output reloadValue, input count, input expired);
  modport cnt  (input load, input step, input reloadValue, output count, output expired);
endinterface : rcw_cnt_if
`default_nettype wire

// ### core/rcw_down_counter.sv
// 29-bit watchdog down-counter with reload and one-shot expiry
`timescale 1ns/1ps
`default_nettype none
module rcw_down_counter #(
  parameter int unsigned WIDTH = rcw_pkg::CNT_WIDTH
) (
  input wire logic core_clk,
  input wire logic nrst,
  rcw_cnt_if.cnt   cnt
);

  logic [WIDTH-1:0] count_q;
  logic             expired_q;
  wire  logic       atOne = (count_q == WIDTH'(1));
  wire  logic       run   = cnt.step && (count_q != '0);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      count_q   <= '0;
      expired_q <= 1'b0;
    end else if (cnt.load) begin
      count_q   <= cnt.reloadValue;
      expired_q <= 1'b0;
    end else if (run) begin
      count_q   <= count_q - WIDTH'(1);
      expired_q <= atOne;
    end
  end

  assign cnt.count   = count_q;
  assign cnt.expired = expired_q;

endmodule : rcw_down_counter
`default_nettype wire

// ### core/rcw_ctrl_regs.sv
// upgrade control and status registers with trigger-dependent update
`timescale 1ns/1ps
`default_nettype none
module rcw_ctrl_regs (
  input  wire logic                           core_clk,
  input  wire logic                           nrst,
  input  wire logic                           factoryWrite,
  input  wire logic [rcw_pkg::CTRL_WIDTH-1:0] factoryData,
  input  wire logic [rcw_pkg::CTRL_WIDTH-1:0] updateData,
  input  wire logic                           statusLoad,
  input  wire logic [rcw_pkg::STAT_WIDTH-1:0] causeVec,
  output logic      [rcw_pkg::CTRL_WIDTH-1:0] controlReg,
  output logic      [rcw_pkg::STAT_WIDTH-1:0] statusReg
);

  logic [rcw_pkg::CTRL_WIDTH-1:0] control_q;
  logic [rcw_pkg::STAT_WIDTH-1:0] status_q;

  // only a pure core trigger keeps configuration; any error cause wins
  wire logic coreOnly = (causeVec == rcw_pkg::STAT_WIDTH'(1 << rcw_pkg::STAT_CORE));

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      control_q <= rcw_pkg::CTRL_RESET;
    end else if (statusLoad) begin
      control_q <= coreOnly ? updateData : rcw_pkg::CTRL_RESET;
    end else if (factoryWrite) begin
      control_q <= factoryData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      status_q <= rcw_pkg::STAT_RESET;
    end else if (statusLoad) begin
      status_q <= causeVec;
    end
  end

  assign controlReg = control_q;
  assign statusReg  = status_q;

endmodule : rcw_ctrl_regs
`default_nettype wire

// ### test/rcw_watchdog_props.sv
// concurrent checks on the reconfiguration watchdog ports
`timescale 1ns/1ps
`default_nettype none
module rcw_watchdog_props (
  input wire logic                           core_clk,
  input wire logic                           nrst,
  input wire logic                           watchdogReloadN,
  input wire logic                           configRestartN,
  input wire logic                           configErrorN,
  input wire logic                           coreReconfigReq,
  input wire logic [rcw_pkg::CTRL_WIDTH-1:0] updateData,
  input wire logic [rcw_pkg::CTRL_WIDTH-1:0] controlReg,
  input wire logic [rcw_pkg::STAT_WIDTH-1:0] statusReg,
  input wire logic                           watchdogTimeout,
  input wire logic                           factoryLoad,
  input wire logic                           userMode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_TO_FLAG: assert property (watchdogTimeout |-> statusReg[4] && controlReg == 13'h0000)
    else $error("time-out without flag or cleared control");
  AST_TO_LOAD: assert property (watchdogTimeout |=> factoryLoad)
    else $error("time-out not followed by factory load");
  AST_STAT_FIRST: assert property (factoryLoad |-> statusReg != 5'h00 && $stable(statusReg))
    else $error("factory load before status update");
  AST_RESTART: assert property ((userMode && !configRestartN) |=> statusReg[0] && controlReg == 13'h0000 ##1 factoryLoad)
    else $error("restart did not clear control");
  AST_CORE: assert property ((userMode && coreReconfigReq && configRestartN && configErrorN) |=> controlReg == $past(updateData))
    else $error("core trigger did not copy update register");
  AST_USER_ONLY: assert property (watchdogTimeout |-> $past(userMode))
    else $error("time-out outside user mode");
  AST_ONE_TO: assert property (watchdogTimeout |=> !watchdogTimeout ##1 !userMode)
    else $error("time-out longer than one cycle");
  AST_HELD: assert property ((userMode && !watchdogReloadN) [*2] |=> !watchdogTimeout)
    else $error("time-out while reload held");
  COV_TO: cover property (watchdogTimeout);
  COV_CORE: cover property (userMode && coreReconfigReq);
  COV_HELD: cover property ((userMode && !watchdogReloadN) [*8]);
endmodule : rcw_watchdog_props
bind rcw_watchdog rcw_watchdog_props props_u (.core_clk(core_clk), .nrst(nrst),
  .watchdogReloadN(watchdogReloadN), .configRestartN(configRestartN),
  .configErrorN(configErrorN), .coreReconfigReq(coreReconfigReq), .updateData(updateData),
  .controlReg(controlReg), .statusReg(statusReg), .watchdogTimeout(watchdogTimeout),
  .factoryLoad(factoryLoad), .userMode(userMode));
`default_nettype wire

// ### test/rcw_app_model.sv
// application logic that pulses the active-low watchdog reload
`timescale 1ns/1ps
`default_nettype none
module rcw_app_model #(
  parameter int HOLD = 50,
  parameter int GAP  = 20
) (
  input  wire logic core_clk,
  input  wire logic reloadEn,
  output var logic  watchdogReloadN
);
  int cnt = 0;
  // 50 cycles of 5 ns give the 250 ns minimum low time
  always @(posedge core_clk) begin
    cnt <= (cnt + 1) % (HOLD + GAP);
    watchdogReloadN <= !(reloadEn && cnt < HOLD);
  end
endmodule : rcw_app_model
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the reconfiguration watchdog
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0, nrst = 1'b0, restartN = 1'b1, errorN = 1'b1, crcErr = 1'b0;
  logic coreReq = 1'b0, entry = 1'b0, fWrite = 1'b0, clkSel = 1'b0, osc = 1'b0;
  logic usrTick = 1'b0, reloadEn = 1'b0, wdTo, fLoad, uMode, reloadN;
  logic [12:0] fData = 13'h0000, upd = 13'h0000, ctrl;
  logic [4:0] stat;
  int fails = 0, comparisons = 0, cyc = 0, seed = 2, n;
  always #2.5 core_clk = ~core_clk;
  rcw_app_model app_u (.core_clk(core_clk), .reloadEn(reloadEn), .watchdogReloadN(reloadN));
  rcw_watchdog dut_u (.core_clk(core_clk), .nrst(nrst), .watchdogReloadN(reloadN),
    .configRestartN(restartN), .configErrorN(errorN), .crcError(crcErr),
    .coreReconfigReq(coreReq), .userModeEntry(entry), .factoryWrite(fWrite),
    .factoryData(fData), .updateData(upd), .userClockSelect(clkSel), .oscTick(osc),
    .userClockInputTick(usrTick), .controlReg(ctrl), .statusReg(stat),
    .watchdogTimeout(wdTo), .factoryLoad(fLoad), .userMode(uMode));
  function automatic logic [12:0] expCtrl(input int k, input logic [12:0] u);
    return (k == 3) ? u : 13'h0000;
  endfunction : expCtrl
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic session(input logic [11:0] field);
    @(posedge core_clk);
    fWrite <= 1'b1;
    fData <= {1'b1, field};
    @(posedge core_clk);
    fWrite <= 1'b0;
    entry <= 1'b1;
    @(posedge core_clk);
    entry <= 1'b0;
  endtask : session
  task automatic waitTo(input int lim);
    n = 0;
    while (wdTo !== 1'b1 && n < lim) begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask : waitTo
  task automatic trig(input int k);
    @(posedge core_clk);
    {restartN, errorN, crcErr, coreReq} <= {k != 0, k != 1, k == 2, k == 3};
    @(posedge core_clk);
    {restartN, errorN, crcErr, coreReq} <= 4'hc;
    #1;
  endtask : trig
  // user ticks every fourth cycle, so a wrong clock select shows up
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    usrTick <= (cyc % 4 == 0);
    if (cyc == 5000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    osc <= 1'b1;
    session(12'h000);
    waitTo(40);
    chk(13'(n >= 8 && n <= 12), 13'h0001);
    chk(13'(stat), 13'h0010);
    chk(ctrl, 13'h0000);
    @(posedge core_clk);
    #1;
    chk(13'(fLoad), 13'h0001);
    osc <= 1'b0;
    session(12'h000);
    repeat (60) @(posedge core_clk);
    #1;
    chk(13'(uMode), 13'h0001);
    clkSel <= 1'b1;
    osc <= 1'b1;
    reloadEn <= 1'b1;
    repeat (400) @(posedge core_clk);
    #1;
    chk(13'(uMode), 13'h0001);
    reloadEn <= 1'b0;
    waitTo(100);
    chk(13'(stat), 13'h0010);
    osc <= 1'b0;
    repeat (3) @(posedge core_clk);
    for (int k = 0; k < 4; k++) begin
      if (k != 2)
        session(12'h000);
      upd <= 13'($random(seed));
      trig(k);
      chk(ctrl, expCtrl(k, upd));
      chk(13'(stat), 13'h0001 << k);
      repeat (3) @(posedge core_clk);
    end
    conclude();
  end
endmodule : testbench
`default_nettype wire
